// ===== verilog/fsp_params.svh
// Constants for the flash status and block-protect block
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH

// Opcodes
`define FSP_CMD_WRITE_STATE 8'h01
`define FSP_CMD_PROGRAM 8'h02
`define FSP_CMD_WRITE_DISARM 8'h04
`define FSP_CMD_READ_STATE 8'h05
`define FSP_CMD_WRITE_ARM 8'h06
`define FSP_CMD_PROGRAM_LP 8'h0A
`define FSP_CMD_SMALL_ERASE_A 8'h20
`define FSP_CMD_SMALL_ERASE_B 8'hD7
`define FSP_CMD_SECTOR_ERASE 8'hD8
`define FSP_CMD_FULL_ERASE_A 8'h60
`define FSP_CMD_FULL_ERASE_B 8'hC7
`define FSP_CMD_SUSPEND 8'hB0
`define FSP_CMD_RESUME 8'h30

// Status field positions
`define FSP_BIT_BUSY 0
`define FSP_BIT_WEL 1
`define FSP_BIT_LEVEL_LO 2
`define FSP_BIT_LEVEL_HI 4
`define FSP_BIT_SIDE 5
`define FSP_BIT_SUSPEND 6
`define FSP_BIT_LOCK 7
`define FSP_STATUS_RESET 8'h00

// Address map
`define FSP_SECTOR_COUNT 6'h20
`define FSP_SECTOR_MASK 24'hFF0000
`define FSP_SMALL_MASK 24'hFFF000
`define FSP_ADDR_BITS 24

// Bytes a complete command carries
`define FSP_LEN_SIMPLE 3'h1
`define FSP_LEN_STATE 3'h2
`define FSP_LEN_ADDR 3'h4
`define FSP_LEN_PROGRAM 3'h5

// Cycles an internal status-register write stays busy
`define FSP_STATUS_WRITE_CYCLES 16

`endif

// ===== verilog/fsp_pkg.sv
// Types for the flash status and block-protect block
package fsp_pkg;
  `include "fsp_params.svh"

  typedef enum logic [2:0] {
    FSP_OP_SMALL_ERASE,
    FSP_OP_SECTOR_ERASE,
    FSP_OP_FULL_ERASE,
    FSP_OP_PROGRAM,
    FSP_OP_PROGRAM_LP
  } fsp_op_e;

  typedef enum logic [1:0] {
    FSP_WIP_IDLE,
    FSP_WIP_STATE,
    FSP_WIP_ARRAY
  } fsp_wip_e;

  typedef struct packed {
    logic [3:0] cs_sync;
    logic [1:0] wp_sync;
    logic [2:0] tg_sync;
    logic [1:0] ack_sync;
    logic pub_req;
    logic [7:0] pub_data;
    logic [2:0] byte_idx;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] wdata;
    logic busy;
    logic wel;
    logic susp;
    logic [2:0] level;
    logic side;
    logic lock;
    fsp_wip_e wip;
    logic [15:0] timer;
    logic start;
    fsp_op_e kind;
    logic [23:0] op_addr;
    logic suspend;
    logic resume;
  } fsp_main_s;

  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [6:0] shift_in;
    logic first_done;
    logic rd_stat;
    logic [7:0] out_shift;
  } fsp_frame_s;

  typedef struct packed {
    logic [7:0] byte_val;
    logic byte_tgl;
    logic [1:0] req_sync;
    logic ack;
    logic [7:0] copy;
  } fsp_hold_s;
endpackage

// ===== verilog/fsp_link.sv
// Serial-clock side of the flash status block: byte capture and status shift-out
`timescale 1ns/1ps
`include "fsp_params.svh"
module fsp_link import fsp_pkg::*; (
  input wire logic sck_in,            // Serial clock from host
  input wire logic cs_n_in,           // Chip select, low in a frame
  input wire logic reset_n_in,        // Chip reset, active low
  input wire logic mosi_in,           // Serial data in
  input wire logic [7:0] stat_data_in, // Published status byte
  input wire logic stat_req_in,       // Publish toggle
  output logic stat_ack_out,          // Publish acknowledge toggle
  output logic [7:0] byte_val_out,    // Last complete byte
  output logic byte_tgl_out,          // Flips per complete byte
  output logic miso_out,              // Serial data out
  output logic miso_oe_n_out          // Low while driving serial out
);
  fsp_frame_s f_reg;
  fsp_frame_s f_next;
  fsp_hold_s h_reg;
  fsp_hold_s h_next;
  logic [7:0] byte_now;
  logic frame_rst_n;

  // Frame state lives only while select is low
  assign frame_rst_n = reset_n_in & ~cs_n_in;

  always_comb begin
    f_next = f_reg;
    h_next = h_reg;
    byte_now = {f_reg.shift_in, mosi_in};
    f_next.bit_cnt = f_reg.bit_cnt + 3'h1;
    f_next.shift_in = byte_now[6:0];
    h_next.req_sync = {h_reg.req_sync[0], stat_req_in};
    if (h_reg.req_sync[1] != h_reg.ack) begin
      h_next.copy = stat_data_in;
      h_next.ack = h_reg.req_sync[1];
    end
    if (f_reg.rd_stat) begin
      f_next.out_shift = {f_reg.out_shift[6:0], 1'b0};
    end
    if (f_reg.bit_cnt == 3'h7) begin
      h_next.byte_val = byte_now;
      h_next.byte_tgl = ~h_reg.byte_tgl;
      f_next.first_done = 1'b1;
      if (!f_reg.first_done && byte_now == `FSP_CMD_READ_STATE) begin
        f_next.rd_stat = 1'b1;
      end
      if (f_next.rd_stat) begin
        f_next.out_shift = h_reg.copy;
      end
    end
  end

  always_ff @(posedge sck_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end

  always_ff @(posedge sck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      h_reg <= '0;
    end else begin
      h_reg <= h_next;
    end
  end

  assign miso_out = f_reg.out_shift[7];
  assign miso_oe_n_out = ~f_reg.rd_stat;
  assign stat_ack_out = h_reg.ack;
  assign byte_val_out = h_reg.byte_val;
  assign byte_tgl_out = h_reg.byte_tgl;
endmodule

// ===== verilog/fsp_status_top.sv
// Status register and block protection of a serial flash
`timescale 1ns/1ps
`include "fsp_params.svh"
module fsp_status_top import fsp_pkg::*; #(
  parameter int unsigned STATUS_WRITE_CYCLES = `FSP_STATUS_WRITE_CYCLES
) (
  input wire logic clk_in,                // System clock, 40 MHz
  input wire logic reset_n_in,            // Asynchronous reset, active low
  input wire logic sck_in,                // Serial clock from host
  input wire logic cs_n_in,               // Chip select, active low
  input wire logic mosi_in,               // Serial data in
  input wire logic wp_n_in,               // Write-protect pin, active low
  output logic miso_out,                  // Serial data out
  output logic miso_oe_n_out,             // Low while serial out is driven
  input wire logic array_done_in,         // Array engine finished, one pulse
  output logic array_start_out,           // Start erase or program, one pulse
  output logic [2:0] array_kind_out,      // Kind of array operation
  output logic [23:0] array_addr_out,     // Target address, aligned for erases, as sent for programs
  output logic array_suspend_out,         // Suspend array engine, one pulse
  output logic array_resume_out,          // Resume array engine, one pulse
  output logic [7:0] status_out           // Live status register
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  function automatic logic [7:0] status_byte(input fsp_main_s s);
    logic [7:0] v;
    v = `FSP_STATUS_RESET;
    v[`FSP_BIT_BUSY] = s.busy;
    v[`FSP_BIT_WEL] = s.wel;
    v[`FSP_BIT_LEVEL_HI:`FSP_BIT_LEVEL_LO] = s.level;
    v[`FSP_BIT_SIDE] = s.side;
    v[`FSP_BIT_SUSPEND] = s.susp;
    v[`FSP_BIT_LOCK] = s.lock;
    return v;
  endfunction

  // Protected ranges are whole sectors, so the sector number decides
  function automatic logic addr_protected(input logic [23:0] a, input logic [2:0] lvl,
                                          input logic tb);
    logic [5:0] sec;
    logic [5:0] span;
    sec = {1'b0, a[20:16]};
    span = 6'h01 << (lvl - 3'h1);
    if (lvl == 3'h0) begin
      return 1'b0;
    end
    if (lvl[2:1] == 2'b11) begin
      return 1'b1;
    end
    if (tb) begin
      return sec < span;
    end
    return sec >= (`FSP_SECTOR_COUNT - span);
  endfunction

  // Bytes that a frame must carry before its command counts
  function automatic logic [2:0] frame_need(input logic [7:0] op);
    logic [2:0] n;
    n = `FSP_LEN_SIMPLE;
    case (op)
      `FSP_CMD_WRITE_STATE: begin
        n = `FSP_LEN_STATE;
      end
      `FSP_CMD_SMALL_ERASE_A, `FSP_CMD_SMALL_ERASE_B, `FSP_CMD_SECTOR_ERASE: begin
        n = `FSP_LEN_ADDR;
      end
      `FSP_CMD_PROGRAM, `FSP_CMD_PROGRAM_LP: begin
        n = `FSP_LEN_PROGRAM;
      end
      default: begin
        n = `FSP_LEN_SIMPLE;
      end
    endcase
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Serial link
  // ----------------------------------------------------------------

  fsp_main_s r_reg;
  fsp_main_s r_next;
  logic stat_ack;
  logic [7:0] byte_val;
  logic byte_tgl;

  fsp_link u_link (
    .sck_in(sck_in),
    .cs_n_in(cs_n_in),
    .reset_n_in(reset_n_in),
    .mosi_in(mosi_in),
    .stat_data_in(r_reg.pub_data),
    .stat_req_in(r_reg.pub_req),
    .stat_ack_out(stat_ack),
    .byte_val_out(byte_val),
    .byte_tgl_out(byte_tgl),
    .miso_out(miso_out),
    .miso_oe_n_out(miso_oe_n_out)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  logic cs_rise;
  logic cs_fall;
  logic byte_ev;
  logic state_open;
  logic arm_ok;
  logic is_array;
  logic array_ok;
  logic [2:0] need;
  fsp_op_e op_kind;
  logic [23:0] op_base;
  logic [7:0] cur_status;
  logic frame_whole;

  always_comb begin
    r_next = r_reg;
    cs_rise = 1'b0;
    cs_fall = 1'b0;
    byte_ev = 1'b0;
    state_open = 1'b0;
    arm_ok = 1'b0;
    is_array = 1'b0;
    array_ok = 1'b0;
    need = `FSP_LEN_ADDR;
    op_kind = FSP_OP_PROGRAM;
    op_base = r_reg.addr;
    cur_status = status_byte(r_reg);
    frame_whole = 1'b0;
    r_next.start = 1'b0;
    r_next.suspend = 1'b0;
    r_next.resume = 1'b0;

    // Pin and toggle synchronisers; select gets one extra stage
    r_next.cs_sync = {r_reg.cs_sync[2:0], cs_n_in};
    r_next.wp_sync = {r_reg.wp_sync[0], wp_n_in};
    r_next.tg_sync = {r_reg.tg_sync[1:0], byte_tgl};
    r_next.ack_sync = {r_reg.ack_sync[0], stat_ack};
    cs_rise = r_reg.cs_sync[2] & ~r_reg.cs_sync[3];
    cs_fall = ~r_reg.cs_sync[2] & r_reg.cs_sync[3];
    byte_ev = r_reg.tg_sync[1] ^ r_reg.tg_sync[2];

    // Collect the bytes of the current frame
    if (cs_fall) begin
      r_next.byte_idx = 3'h0;
    end
    if (byte_ev) begin
      case (r_next.byte_idx)
        3'h0: r_next.opcode = byte_val;
        3'h1: begin
          r_next.addr[23:16] = byte_val;
          r_next.wdata = byte_val;
        end
        3'h2: r_next.addr[15:8] = byte_val;
        3'h3: r_next.addr[7:0] = byte_val;
        default: begin
        end
      endcase
      if (r_next.byte_idx < `FSP_LEN_PROGRAM) begin
        r_next.byte_idx = r_next.byte_idx + 3'h1;
      end
    end

    if (r_reg.wip == FSP_WIP_STATE) begin
      if (r_reg.timer != 16'h0000) begin
        r_next.timer = r_reg.timer - 16'h0001;
      end else begin
        r_next.busy = 1'b0;
        r_next.wel = 1'b0;
        r_next.wip = FSP_WIP_IDLE;
      end
    end

    if (array_done_in && r_reg.busy && r_reg.wip == FSP_WIP_ARRAY) begin
      r_next.busy = 1'b0;
      r_next.wel = 1'b0;
      r_next.wip = FSP_WIP_IDLE;
    end

    // Decode the array commands
    case (r_next.opcode)
      `FSP_CMD_SMALL_ERASE_A, `FSP_CMD_SMALL_ERASE_B: begin
        is_array = 1'b1;
        op_kind = FSP_OP_SMALL_ERASE;
        op_base = r_next.addr & `FSP_SMALL_MASK;
      end
      `FSP_CMD_SECTOR_ERASE: begin
        is_array = 1'b1;
        op_kind = FSP_OP_SECTOR_ERASE;
        op_base = r_next.addr & `FSP_SECTOR_MASK;
      end
      `FSP_CMD_FULL_ERASE_A, `FSP_CMD_FULL_ERASE_B: begin
        is_array = 1'b1;
        op_kind = FSP_OP_FULL_ERASE;
        need = `FSP_LEN_SIMPLE;
        op_base = {`FSP_ADDR_BITS{1'b0}};
      end
      `FSP_CMD_PROGRAM: begin
        is_array = 1'b1;
        need = `FSP_LEN_PROGRAM;
      end
      `FSP_CMD_PROGRAM_LP: begin
        is_array = 1'b1;
        op_kind = FSP_OP_PROGRAM_LP;
        need = `FSP_LEN_PROGRAM;
      end
      default: begin
      end
    endcase

    arm_ok = r_next.wel;
    array_ok = arm_ok && r_next.byte_idx >= need
               && !addr_protected(op_base, r_next.level, r_next.side);
    if (op_kind == FSP_OP_FULL_ERASE && r_next.level != 3'h0) begin
      array_ok = 1'b0;
    end
    // Lock with pin low closes status-register writes
    state_open = !(r_next.lock && !r_reg.wp_sync[1]);
    // Cut frames never replay an old opcode
    frame_whole = r_next.byte_idx >= frame_need(r_next.opcode);

    // Commands take effect when select rises; a busy part only accepts suspend
    if (cs_rise && frame_whole && (!r_next.busy || r_next.opcode == `FSP_CMD_SUSPEND)) begin
      if (is_array) begin
        // Refused commands leave the latch alone
        if (array_ok) begin
          r_next.busy = 1'b1;
          r_next.wip = FSP_WIP_ARRAY;
          // New erase or program clears suspend
          r_next.susp = 1'b0;
          r_next.start = 1'b1;
          r_next.kind = op_kind;
          r_next.op_addr = op_base;
        end
      end else begin
        case (r_next.opcode)
          `FSP_CMD_WRITE_ARM: r_next.wel = 1'b1;
          `FSP_CMD_WRITE_DISARM: r_next.wel = 1'b0;
          `FSP_CMD_WRITE_STATE: begin
            if (arm_ok && state_open && r_next.byte_idx >= `FSP_LEN_STATE) begin
              r_next.level = r_next.wdata[`FSP_BIT_LEVEL_HI:`FSP_BIT_LEVEL_LO];
              r_next.side = r_next.wdata[`FSP_BIT_SIDE];
              r_next.lock = r_next.wdata[`FSP_BIT_LOCK];
              r_next.busy = 1'b1;
              r_next.wip = FSP_WIP_STATE;
              r_next.timer = 16'(STATUS_WRITE_CYCLES - 1);
            end
          end
          `FSP_CMD_SUSPEND: begin
            if (r_next.busy && r_next.wip == FSP_WIP_ARRAY) begin
              r_next.susp = 1'b1;
              r_next.busy = 1'b0;
              r_next.suspend = 1'b1;
            end
          end
          `FSP_CMD_RESUME: begin
            if (r_next.susp) begin
              r_next.susp = 1'b0;
              r_next.busy = 1'b1;
              r_next.resume = 1'b1;
            end
          end
          // Reads and others leave the latch
          default: begin
          end
        endcase
      end
    end

    // Publish a changed status byte to the link, one handshake at a time
    if (r_reg.ack_sync[1] == r_reg.pub_req && r_reg.pub_data != cur_status) begin
      r_next.pub_data = cur_status;
      r_next.pub_req = ~r_reg.pub_req;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r_reg <= '0;
      r_reg.cs_sync <= 4'hF;
      r_reg.wp_sync <= 2'h3;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  assign array_start_out = r_reg.start;
  assign array_kind_out = r_reg.kind;
  assign array_addr_out = r_reg.op_addr;
  assign array_suspend_out = r_reg.suspend;
  assign array_resume_out = r_reg.resume;
  assign status_out = status_byte(r_reg);
endmodule

// ===== sim/fsp_status_props.sv
// Port-level assertions for the flash status and block-protect block
`timescale 1ns/1ps
module fsp_status_props #(
  parameter int unsigned STATUS_WRITE_CYCLES = 16
) (
  input wire logic clk_in, // System clock
  input wire logic reset_n_in, // Reset, active low
  input wire logic sck_in, // Serial clock
  input wire logic cs_n_in, // Chip select
  input wire logic mosi_in, // Serial in
  input wire logic wp_n_in, // Write-protect pin
  input wire logic miso_out, // Serial out
  input wire logic miso_oe_n_out, // Serial out enable
  input wire logic array_done_in, // Engine done
  input wire logic array_start_out, // Engine start
  input wire logic [2:0] array_kind_out, // Operation kind
  input wire logic [23:0] array_addr_out, // Operation base
  input wire logic array_suspend_out, // Suspend pulse
  input wire logic array_resume_out, // Resume pulse
  input wire logic [7:0] status_out // Live status
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // True when the address falls in the range the status bits protect
  function automatic logic prot(input logic [7:0] s, input logic [23:0] a);
    logic [20:0] size;
    size = 21'h010000 << (s[4:2] - 3'h1);
    if (s[4:2] == 3'h0)
      return 1'b0;
    if (s[4:3] == 2'b11)
      return 1'b1;
    return s[5] ? (a[20:0] < size) : (a[20:0] > (21'h1FFFFF - size));
  endfunction

  a_start_when_armed: assert property (array_start_out |-> status_out[1:0] == 2'b11)
    else $error("start without busy and write latch");
  a_busy_needs_wel: assert property ($rose(status_out[0]) |-> $past(status_out[1]))
    else $error("busy rose with write latch low");
  a_done_clears_wel: assert property (array_done_in && status_out[0] |=>
    status_out[1:0] == 2'b00) else $error("completion left busy or latch set");
  a_full_erase_gate: assert property (array_start_out && array_kind_out == 3'h2 |->
    status_out[4:2] == 3'h0 && array_addr_out == 24'h000000)
    else $error("full erase with nonzero level");
  a_top_range: assert property (array_start_out && !status_out[5] |->
    !prot(status_out, array_addr_out)) else $error("start inside top range");
  a_bottom_range: assert property (array_start_out && status_out[5] |->
    !prot(status_out, array_addr_out)) else $error("start inside bottom range");
  a_whole_protect: assert property (array_start_out |-> status_out[4:3] != 2'b11)
    else $error("start with whole array protected");
  a_sector_align: assert property (array_start_out && array_kind_out == 3'h1 |->
    array_addr_out[15:0] == 16'h0000) else $error("sector base misaligned");
  a_small_align: assert property (array_start_out && array_kind_out == 3'h0 |->
    array_addr_out[11:0] == 12'h000) else $error("small sector base misaligned");
  a_suspend_flag: assert property (array_suspend_out |-> ##[0:1]
    (status_out[6] && !status_out[0])) else $error("suspend flag not shown");
  a_resume_flag: assert property (array_resume_out |-> ##[0:1]
    (!status_out[6] && status_out[0])) else $error("resume flag not cleared");
  a_out_released: assert property (cs_n_in |-> miso_oe_n_out)
    else $error("serial out driven while deselected");
endmodule

bind fsp_status_top fsp_status_props #(.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) u_props (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .sck_in(sck_in), .cs_n_in(cs_n_in),
  .mosi_in(mosi_in), .wp_n_in(wp_n_in), .miso_out(miso_out), .miso_oe_n_out(miso_oe_n_out),
  .array_done_in(array_done_in), .array_start_out(array_start_out),
  .array_kind_out(array_kind_out), .array_addr_out(array_addr_out),
  .array_suspend_out(array_suspend_out), .array_resume_out(array_resume_out),
  .status_out(status_out)
);

// ===== sim/fsp_host_model.sv
// Host serial controller model that sends command frames
`timescale 1ns/1ps
module fsp_host_model (
  output logic sck_out, // Serial clock, still between frames
  output logic cs_n_out, // Chip select
  output logic mosi_out, // Serial data to device
  input wire logic miso_in, // Serial data from device
  input wire logic miso_oe_n_in // Low while device drives
);
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // Every command, arm and disarm too, goes out as one whole frame
  task automatic frame(input logic [7:0] cmd[$], input int nrd, output logic [15:0] rd);
    logic [7:0] b;
    rd = 16'hXXXX;
    cs_n_out = 1'b0;
    for (int i = 0; i < cmd.size() + nrd; i++) begin
      b = (i < cmd.size()) ? cmd[i] : 8'hAA;
      for (int k = 7; k >= 0; k--) begin
        mosi_out = b[k];
        #16;
        if (i >= cmd.size())
          rd = {rd[14:0], miso_oe_n_in ? 1'bx : miso_in};
        sck_out = 1'b1;
        #16;
        sck_out = 1'b0;
      end
    end
    #32;
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #200;
  endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the flash status and block-protect block
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin checks++; if ((sn) !== (ex)) begin bad_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, sn); end end
module testbench;
  // Row layout: status data, opcode, address, accepted, expected kind
  typedef struct packed {
    logic [7:0] sr;
    logic [7:0] op;
    logic [23:0] adr;
    logic ok;
    logic [2:0] kd;
  } fsp_row_s;
  fsp_row_s rows [0:26] = '{
    44'h00_C7_000000_A, 44'h04_60_000000_2, 44'h04_D8_1F0000_1, 44'h04_20_1EF000_8,
    44'h08_D7_1E0000_0, 44'h08_D8_1D0000_9, 44'h0C_D8_1C0000_1, 44'h0C_D8_1B0000_9,
    44'h10_20_180000_0, 44'h10_20_17F000_8, 44'h14_D8_100000_1, 44'h14_D8_0F0000_9,
    44'h24_D8_00FFFF_1, 44'h24_20_010000_8, 44'h28_20_01F000_0, 44'h28_D8_020000_9,
    44'h2C_D8_03F000_1, 44'h2C_D8_040000_9, 44'h30_20_07F000_0, 44'h30_D8_080000_9,
    44'h34_D8_0FFFFF_1, 44'h34_D7_100000_8, 44'h18_D8_000000_1, 44'h38_D8_1FFFFF_1,
    44'h1C_20_100000_0, 44'h3C_60_000000_2, 44'h00_D8_1FFFFF_9};
  fsp_row_s r;
  logic clk_in, reset_n_in, wp_n_in, array_done_in, sck, cs_n, mosi, miso_out, miso_oe_n_out;
  logic array_start_out, array_suspend_out, array_resume_out;
  logic [2:0] array_kind_out, kind_seen;
  logic [23:0] array_addr_out, addr_seen;
  logic [7:0] status_out;
  logic [15:0] rd;
  int checks = 0, bad_count = 0, starts = 0, susps = 0, resms = 0, n0;

  fsp_status_top #(.STATUS_WRITE_CYCLES(4)) dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .sck_in(sck), .cs_n_in(cs_n), .mosi_in(mosi),
    .wp_n_in(wp_n_in), .miso_out(miso_out), .miso_oe_n_out(miso_oe_n_out),
    .array_done_in(array_done_in), .array_start_out(array_start_out),
    .array_kind_out(array_kind_out), .array_addr_out(array_addr_out),
    .array_suspend_out(array_suspend_out), .array_resume_out(array_resume_out),
    .status_out(status_out));
  fsp_host_model u_host (.sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi),
    .miso_in(miso_out), .miso_oe_n_in(miso_oe_n_out));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  // Pulses stand a whole cycle, so the falling edge sees them settled
  always @(negedge clk_in) begin
    if (array_start_out === 1'b1) begin
      starts++;
      kind_seen = array_kind_out;
      addr_seen = array_addr_out;
    end
    if (array_suspend_out === 1'b1)
      susps++;
    if (array_resume_out === 1'b1)
      resms++;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] q[$]);
    u_host.frame(q, 0, rd);
    @(negedge clk_in);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (status_out[0] !== 1'b0 && n < 400) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 400) begin
      bad_count++;
      conclude;
    end
  endtask
  task automatic set_sr(input logic [7:0] d);
    cmd('{8'h06});
    cmd('{8'h01, d});
    wait_idle;
  endtask
  task automatic done_pulse;
    array_done_in = 1'b1;
    @(negedge clk_in);
    array_done_in = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask

  initial begin
    reset_n_in = 1'b0;
    wp_n_in = 1'b1;
    array_done_in = 1'b0;
    repeat (16) @(negedge clk_in);
    `CHK("reset status", 8'h00, status_out)
    `CHK("reset oe", 1'b1, miso_oe_n_out)
    reset_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    foreach (rows[i]) begin
      r = rows[i];
      set_sr(r.sr);
      `CHK("kept bits", r.sr[7:2], status_out[7:2])
      `CHK("wel after write", 1'b0, status_out[1])
      n0 = starts;
      cmd('{8'h06});
      cmd('{r.op, r.adr[23:16], r.adr[15:8], r.adr[7:0]});
      `CHK("start count", n0 + int'(r.ok), starts)
      `CHK("busy", r.ok, status_out[0])
      `CHK("wel kept", 1'b1, status_out[1])
      if (r.ok) begin
        `CHK("kind", r.kd, kind_seen)
        `CHK("base", r.adr & (r.op == 8'hD8 ? 24'hFF0000 : 24'hFFF000), addr_seen)
        done_pulse;
        `CHK("done", 2'b00, status_out[1:0])
      end else begin
        cmd('{8'h04});
        `CHK("disarm", 1'b0, status_out[1])
      end
    end
    n0 = starts;
    cmd('{8'hD8, 8'h00, 8'h00, 8'h00});
    cmd('{8'h01, 8'h10});
    `CHK("no arm start", n0, starts)
    `CHK("no arm write", 8'h00, status_out)
    set_sr(8'hC3);
    `CHK("read-only bits", 8'h80, status_out)
    wp_n_in = 1'b0;
    cmd('{8'h06});
    cmd('{8'h01, 8'h14});
    wait_idle;
    `CHK("locked", 8'h82, status_out)
    wp_n_in = 1'b1;
    cmd('{8'h01, 8'h00});
    wait_idle;
    `CHK("unlocked", 8'h00, status_out)
    cmd('{8'h06});
    u_host.frame('{8'h05}, 2, rd);
    `CHK("state read", 16'h0202, rd)
    `CHK("read keeps wel", 1'b1, status_out[1])
    n0 = starts;
    cmd('{8'hD8, 8'h00});
    `CHK("short frame", n0, starts)
    `CHK("short keeps wel", 8'h02, status_out)
    cmd('{8'h0A, 8'h00, 8'h10, 8'h00, 8'h5A});
    `CHK("low power kind", 3'h4, kind_seen)
    cmd('{8'hB0});
    `CHK("suspended", 2'b10, {status_out[6], status_out[0]})
    cmd('{8'h30});
    `CHK("resumed", 2'b01, {status_out[6], status_out[0]})
    `CHK("pulses", 2, susps + resms)
    cmd('{8'hB0});
    cmd('{8'h02, 8'h00, 8'h20, 8'h00, 8'hA5});
    `CHK("new op", 4'h3, {status_out[6], kind_seen})
    done_pulse;
    `CHK("op done", 8'h00, status_out)
    set_sr(8'h08);
    cmd('{8'h06});
    reset_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    `CHK("mid reset", 8'h00, status_out)
    reset_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    cmd('{8'h06});
    u_host.frame('{8'h05}, 2, rd);
    `CHK("read after reset", 16'h0202, rd)
    conclude;
  end
endmodule
